// ---- rtl/pbc_basic_control.sv ----
/*
 * Port PHY basic control register, index 0, with strap defaults, loader rewrite,
 * soft reset, autoneg restart, forced speed/duplex, loopback, power down and
 * collision test. Status index 1 shows only the negotiation-complete bit.
 * Assumes a management access engine on mclk issuing one-cycle read/write
 * strobes, a loader on mclk, and straps and link activity arriving from pins.
 */
//
// Contract
// (RULE_01) Soft reset bit restores defaults, self-clears
// (RULE_02) Loopback returns fabric transmit as receive
// (RULE_03) Host sets receive-own-transmit for half duplex loopback
// (RULE_04) Forced speed bit: zero 10, one 100
// (RULE_05) Autoneg enable overrides forced speed, duplex
// (RULE_06) Power down bit enters general power down
// (RULE_07) Negotiation complete sets status bit five
// (RULE_08) Host clears autoneg before setting power down
// (RULE_09) Restart bit restarts autoneg, self-clears
// (RULE_10) Forced duplex bit: zero half, one full
// (RULE_11) Collision test asserts collision during transmit
// (RULE_12) Host uses collision test with loopback
// (RULE_13) Loader rewrites whole register after reset, reload
// (RULE_14) Speed default is autoneg strap OR speed strap
// (RULE_15) Autoneg enable default equals autoneg strap
// (RULE_16) Duplex default is NOT autoneg AND duplex
// (RULE_17) Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "pbc_defs.svh"
module pbc_basic_control
    import pbc_pkg::*;
#(
    parameter int AN_CYCLES = `PBC_AN_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [4:0]  mgmt_index,
    input  wire logic        mgmt_write,
    input  wire logic        mgmt_read,
    input  wire logic [15:0] mgmt_wdata,
    output logic      [15:0] mgmt_rdata,
    input  wire logic        loader_valid,
    input  wire logic [15:0] loader_data,
    input  wire logic        autoneg_strap,
    input  wire logic        speed_strap,
    input  wire logic        duplex_strap,
    input  wire logic        partner_present,
    input  wire logic        fabric_tx_en,
    input  wire logic [3:0]  fabric_txd,
    output logic             fabric_rx_dv,
    output logic      [3:0]  fabric_rxd,
    output logic             fabric_col,
    input  wire logic        line_rx_dv,
    input  wire logic [3:0]  line_rxd,
    output logic             line_tx_en,
    output logic      [3:0]  line_txd,
    output logic             speed_100,
    output logic             full_duplex,
    output logic             power_down,
    output logic             autoneg_done,
    output logic             phy_regs_reset
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic an_strap_s;
    logic spd_strap_s;
    logic dup_strap_s;
    logic partner_s;

    pbc_sync u_sync_an (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (autoneg_strap),
        .dout  (an_strap_s)
    );
    pbc_sync u_sync_spd (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (speed_strap),
        .dout  (spd_strap_s)
    );
    pbc_sync u_sync_dup (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (duplex_strap),
        .dout  (dup_strap_s)
    );
    pbc_sync u_sync_partner (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (partner_present),
        .dout  (partner_s)
    );

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    logic [15:0]      ctrl;
    logic [15:0]      next_ctrl;
    logic [15:0]      strap_default;
    logic [1:0]       boot;
    logic [1:0]       next_boot;
    logic             restart_req;
    logic             next_restart_req;
    logic             soft_reset;
    logic             next_soft_reset;

    always_comb begin
        strap_default = `PBC_FIXED_DEFAULT;
        strap_default[`PBC_SPEED_BIT]     = an_strap_s | spd_strap_s;   // RULE_14
        strap_default[`PBC_AN_ENABLE_BIT] = an_strap_s;                 // RULE_15
        strap_default[`PBC_DUPLEX_BIT]    = ~an_strap_s & dup_strap_s;  // RULE_16
    end

    always_comb begin
        next_ctrl        = ctrl;
        next_boot        = boot;
        next_restart_req = 1'b0;
        next_soft_reset  = 1'b0;
        if (boot != 2'h3) begin
            next_boot = boot + 2'h1;
            if (boot == 2'h2) begin
                next_ctrl = strap_default;
            end
        end else if (ctrl[`PBC_SOFT_RESET_BIT]) begin
            next_ctrl       = strap_default;                            // RULE_01
            next_soft_reset = 1'b1;                                     // RULE_01
        end else if (loader_valid) begin
            next_ctrl        = loader_data & `PBC_WRITE_MASK;           // RULE_13
            next_restart_req = loader_data[`PBC_AN_RESTART_BIT];
        end else if (mgmt_write && mgmt_index == `PBC_REG_INDEX) begin
            next_ctrl        = mgmt_wdata & `PBC_WRITE_MASK;            // RULE_17
            next_restart_req = mgmt_wdata[`PBC_AN_RESTART_BIT];         // RULE_09
        end
        next_ctrl[`PBC_AN_RESTART_BIT] = 1'b0;                          // RULE_09
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl        <= `PBC_FIXED_DEFAULT;
            boot        <= 2'h0;
            restart_req <= 1'b0;
            soft_reset  <= 1'b0;
        end else begin
            ctrl        <= next_ctrl;
            boot        <= next_boot;
            restart_req <= next_restart_req;
            soft_reset  <= next_soft_reset;
        end
    end

    // ----------------------------------------------------------------
    // Auto-negotiation sequencer
    // ----------------------------------------------------------------
    pbc_an_state_type an_state;
    pbc_an_state_type next_an_state;
    logic [31:0]      an_count;
    logic [31:0]      next_an_count;
    logic             an_on;

    assign an_on = ctrl[`PBC_AN_ENABLE_BIT] & ~ctrl[`PBC_POWER_DOWN_BIT];

    always_comb begin
        next_an_state = an_state;
        next_an_count = an_count;
        if (!an_on || soft_reset) begin
            next_an_state = pbc_an_idle;
            next_an_count = 32'h0;
        end else if (restart_req) begin
            next_an_state = pbc_an_busy;                                // RULE_09
            next_an_count = 32'h0;
        end else begin
            case (an_state)
                pbc_an_idle: begin
                    next_an_state = pbc_an_busy;                        // RULE_07
                    next_an_count = 32'h0;
                end
                pbc_an_busy: begin
                    if (!partner_s) begin
                        next_an_count = 32'h0;
                    end else if (an_count >= 32'(AN_CYCLES - 1)) begin
                        next_an_state = pbc_an_done;                    // RULE_07
                    end else begin
                        next_an_count = an_count + 32'h1;
                    end
                end
                pbc_an_done: begin
                    if (!partner_s) begin
                        next_an_state = pbc_an_busy;
                        next_an_count = 32'h0;
                    end
                end
                default: begin
                    next_an_state = pbc_an_idle;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            an_state <= pbc_an_idle;
            an_count <= 32'h0;
        end else begin
            an_state <= next_an_state;
            an_count <= next_an_count;
        end
    end

    // ----------------------------------------------------------------
    // Operating mode
    // ----------------------------------------------------------------
    logic        next_speed_100;
    logic        next_full_duplex;
    logic        next_power_down;

    always_comb begin
        next_power_down = ctrl[`PBC_POWER_DOWN_BIT];                    // RULE_06
        if (ctrl[`PBC_AN_ENABLE_BIT]) begin
            next_speed_100   = 1'b1;                                    // RULE_05
            next_full_duplex = 1'b1;                                    // RULE_05
        end else begin
            next_speed_100   = ctrl[`PBC_SPEED_BIT];                    // RULE_04
            next_full_duplex = ctrl[`PBC_DUPLEX_BIT];                   // RULE_10
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            speed_100   <= 1'b0;
            full_duplex <= 1'b0;
            power_down  <= 1'b0;
        end else begin
            speed_100   <= next_speed_100;
            full_duplex <= next_full_duplex;
            power_down  <= next_power_down;
        end
    end

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    logic        next_fabric_rx_dv;
    logic [3:0]  next_fabric_rxd;
    logic        next_fabric_col;
    logic        next_line_tx_en;
    logic [3:0]  next_line_txd;
    logic        pd;

    assign pd = ctrl[`PBC_POWER_DOWN_BIT];

    always_comb begin
        next_fabric_col = ~pd & ctrl[`PBC_COL_TEST_BIT] & fabric_tx_en; // RULE_11
        if (pd) begin                                                   // RULE_06
            next_line_tx_en   = 1'b0;
            next_line_txd     = 4'h0;
            next_fabric_rx_dv = 1'b0;
            next_fabric_rxd   = 4'h0;
        end else if (ctrl[`PBC_LOOPBACK_BIT]) begin
            next_line_tx_en   = 1'b0;                                   // RULE_02
            next_line_txd     = 4'h0;
            next_fabric_rx_dv = fabric_tx_en;                           // RULE_02
            next_fabric_rxd   = fabric_txd;
        end else begin
            next_line_tx_en   = fabric_tx_en;
            next_line_txd     = fabric_txd;
            next_fabric_rx_dv = line_rx_dv;
            next_fabric_rxd   = line_rxd;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fabric_col     <= 1'b0;
            line_tx_en     <= 1'b0;
            line_txd       <= 4'h0;
            fabric_rx_dv   <= 1'b0;
            fabric_rxd     <= 4'h0;
            autoneg_done   <= 1'b0;
            phy_regs_reset <= 1'b0;
        end else begin
            fabric_col     <= next_fabric_col;
            line_tx_en     <= next_line_tx_en;
            line_txd       <= next_line_txd;
            fabric_rx_dv   <= next_fabric_rx_dv;
            fabric_rxd     <= next_fabric_rxd;
            autoneg_done   <= (next_an_state == pbc_an_done);
            phy_regs_reset <= next_soft_reset;                          // RULE_01
        end
    end

    // ----------------------------------------------------------------
    // Management read data
    // ----------------------------------------------------------------
    logic [15:0] next_mgmt_rdata;

    always_comb begin
        next_mgmt_rdata = mgmt_rdata;
        if (mgmt_read) begin
            next_mgmt_rdata = 16'h0000;
            if (mgmt_index == `PBC_REG_INDEX) begin
                next_mgmt_rdata = ctrl & `PBC_WRITE_MASK;               // RULE_17
            end else if (mgmt_index == `PBC_STATUS_INDEX) begin
                next_mgmt_rdata[`PBC_STATUS_AN_DONE] = (an_state == pbc_an_done); // RULE_07
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mgmt_rdata <= 16'h0000;
        end else begin
            mgmt_rdata <= next_mgmt_rdata;
        end
    end
endmodule // pbc_basic_control

// ---- rtl/pbc_defs.svh ----
/*
 * Bit positions, defaults and timing counts for the port PHY basic control register.
 * Assumes inclusion by the pbc_basic_control design module only.
 */
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

`define PBC_REG_INDEX        5'h00
`define PBC_STATUS_INDEX     5'h01
`define PBC_SOFT_RESET_BIT   15
`define PBC_LOOPBACK_BIT     14
`define PBC_SPEED_BIT        13
`define PBC_AN_ENABLE_BIT    12
`define PBC_POWER_DOWN_BIT   11
`define PBC_AN_RESTART_BIT   9
`define PBC_DUPLEX_BIT       8
`define PBC_COL_TEST_BIT     7
`define PBC_STATUS_AN_DONE   5
`define PBC_WRITE_MASK       16'hfb80
`define PBC_FIXED_DEFAULT    16'h0000
`define PBC_AN_TIME_MS       2
`define PBC_CLK_MHZ          50
`define PBC_AN_CYCLES        (`PBC_AN_TIME_MS * 1000 * `PBC_CLK_MHZ)

`endif

// ---- rtl/pbc_pkg.sv ----
/*
 * Types for the port PHY basic control register.
 * Assumes the defs header is available on the include path.
 */
package pbc_pkg;
    typedef enum logic [1:0] {
        pbc_an_idle,
        pbc_an_busy,
        pbc_an_done
    } pbc_an_state_type;
endpackage

// ---- rtl/pbc_sync.sv ----
/*
 * Two flip-flop synchroniser for a single level.
 * Assumes a free-running mclk and asynchronous active-low reset.
 */
`timescale 1ns/1ps
module pbc_sync (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      dout
);
    logic stage1;
    logic next_stage1;
    logic next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end
endmodule // pbc_sync

// ---- test/pbc_basic_control_bench.sv ----
/* Self-checking bench for the basic control block with a host access model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ps
module pbc_basic_control_bench;
logic        mclk, rst_b, mgmt_write, mgmt_read, loader_valid, partner_present;
logic        autoneg_strap, speed_strap, duplex_strap, fabric_tx_en, line_rx_dv;
logic        fabric_rx_dv, fabric_col, line_tx_en, speed_100, full_duplex;
logic        power_down, autoneg_done, phy_regs_reset;
logic [4:0]  mgmt_index;
logic [3:0]  fabric_txd, fabric_rxd, line_rxd, line_txd;
logic [15:0] mgmt_wdata, mgmt_rdata, loader_data, dflt;
wire  [15:0] mode = {11'h0, fabric_col, power_down, speed_100, full_duplex, autoneg_done};
wire  [1:0]  mon  = {phy_regs_reset, autoneg_done};
int          bad_count, check_count;
pbc_basic_control #(.AN_CYCLES(8)) u_dut (.mclk, .rst_b, .mgmt_index, .mgmt_write,
    .mgmt_read, .mgmt_wdata, .mgmt_rdata, .loader_valid, .loader_data, .autoneg_strap,
    .speed_strap, .duplex_strap, .partner_present, .fabric_tx_en, .fabric_txd,
    .fabric_rx_dv, .fabric_rxd, .fabric_col, .line_rx_dv, .line_rxd, .line_tx_en,
    .line_txd, .speed_100, .full_duplex, .power_down, .autoneg_done, .phy_regs_reset);
pbc_host u_host (.mclk, .mgmt_rdata, .mgmt_index, .mgmt_write, .mgmt_read, .mgmt_wdata);
// ----------------------------------------
// Tasks
// ----------------------------------------
task automatic print_verdict();
    $display("counts: bad %0d checks %0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask
task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
        bad_count++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
endtask
task automatic w(input logic [15:0] d);
    u_host.wr(5'h00, d);
    repeat (3) @(negedge mclk);
endtask
task automatic rc(input logic [4:0] i, input logic [15:0] e);
    logic [15:0] d;
    u_host.rd(i, d);
    chk(d, e);
endtask
task automatic wt(input int b, input logic v);
    int n;
    n = 0;
    while (mon[b] !== v && n < 60) begin
        @(negedge mclk);
        n++;
    end
    chk({15'h0, mon[b]}, {15'h0, v});
    if (n == 60) print_verdict();
endtask
task automatic tx(input logic [3:0] d, input logic lb, input logic [15:0] e);
    fabric_tx_en <= 1'b1;
    fabric_txd   <= d;
    repeat (3) @(negedge mclk);
    chk({fabric_col, fabric_rx_dv, line_tx_en, 9'h0, lb ? fabric_rxd : line_txd}, e);
    fabric_tx_en <= 1'b0;
    fabric_txd   <= ~d;
    @(negedge mclk);
endtask
// ----------------------------------------
// Clock and sequence
// ----------------------------------------
initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
end
initial begin
    {rst_b, loader_valid, loader_data, partner_present, fabric_tx_en, fabric_txd} = '0;
    {autoneg_strap, speed_strap, duplex_strap, line_rx_dv, line_rxd} = 8'h05;
    bad_count = 0;
    check_count = 0;
    for (int i = 0; i < 8; i++) begin
        rst_b <= 1'b0;
        {autoneg_strap, speed_strap, duplex_strap} <= 3'(i);
        repeat (8) @(negedge mclk);
        rst_b <= 1'b1;
        dflt = {2'b00, autoneg_strap | speed_strap, autoneg_strap, 3'h0,
                !autoneg_strap & duplex_strap, 8'h00};
        repeat (6) @(negedge mclk);
        rc(5'h00, dflt);
        w(16'h64ff);
        rc(5'h00, 16'h6080);
        chk(mode, 16'h0004);
        tx(4'ha, 1'b1, 16'hc00a);
        w(16'h0100);
        chk(mode, 16'h0002);
        tx(4'h5, 1'b0, 16'h2005);
        u_host.wr(5'h00, 16'h8000);
        wt(1, 1'b1);
        rc(5'h00, dflt);
    end
    loader_data  <= 16'h2100;
    loader_valid <= 1'b1;
    @(negedge mclk);
    loader_valid <= 1'b0;
    rc(5'h00, 16'h2100);
    w(16'h1000);
    chk(mode, 16'h0006);
    partner_present <= 1'b1;
    wt(0, 1'b1);
    rc(5'h01, 16'h0020);
    u_host.wr(5'h00, 16'h1200);
    rc(5'h00, 16'h1000);
    chk(mode, 16'h0006);
    wt(0, 1'b1);
    w(16'h0000);
    w(16'h0800);
    chk(mode, 16'h0008);
    line_rx_dv <= 1'b1;
    repeat (3) @(negedge mclk);
    chk({15'h0, fabric_rx_dv}, 16'h0000);
    line_rx_dv <= 1'b0;
    w(16'h1000);
    wt(0, 1'b1);
    print_verdict();
end
endmodule // pbc_basic_control_bench

// ---- test/pbc_basic_control_chk.sv ----
/* Port-level checker for the basic control block.
   Assumes a single mclk domain and bind onto pbc_basic_control. */
`timescale 1ns/1ps
module pbc_basic_control_chk #(
    parameter int AN_CYCLES = 8
) (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [4:0]  mgmt_index,
    input wire logic        mgmt_read,
    input wire logic [15:0] mgmt_rdata,
    input wire logic        partner_present,
    input wire logic        fabric_tx_en,
    input wire logic [3:0]  fabric_txd,
    input wire logic        fabric_rx_dv,
    input wire logic [3:0]  fabric_rxd,
    input wire logic        fabric_col,
    input wire logic        line_rx_dv,
    input wire logic        line_tx_en,
    input wire logic [3:0]  line_txd,
    input wire logic        speed_100,
    input wire logic        full_duplex,
    input wire logic        power_down,
    input wire logic        autoneg_done,
    input wire logic        phy_regs_reset
);
// ----------------------------------------
// Partner presence counter
// ----------------------------------------
logic [31:0] pres_cnt;
logic [31:0] next_pres_cnt;
always_comb begin
    next_pres_cnt = partner_present ? pres_cnt + 32'h1 : 32'h0;
end
always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) pres_cnt <= 32'h0;
    else pres_cnt <= next_pres_cnt;
end
// ----------------------------------------
// Assertions
// ----------------------------------------
default clocking cb @(posedge mclk); endclocking
default disable iff (!rst_b);
sequence s_rd_ctl;
    mgmt_read && mgmt_index == 5'h00;
endsequence
sequence s_tx_prev;
    $past(fabric_tx_en);
endsequence
rst_pulse_a: assert property (phy_regs_reset |=> !phy_regs_reset)
    else $error("soft reset pulse longer than one cycle");
lb_loop_a: assert property (fabric_rx_dv && !$past(line_rx_dv) |->
    s_tx_prev ##0 (fabric_rxd == $past(fabric_txd) && !line_tx_en))
    else $error("looped frame wrong or leaked to line");
fwd_path_a: assert property (line_tx_en |-> s_tx_prev ##0 line_txd == $past(fabric_txd))
    else $error("line transmit without fabric transmit");
an_mode_a: assert property (autoneg_done |-> speed_100 && full_duplex)
    else $error("negotiated mode not shown as 100 full");
pd_quiet_a: assert property (power_down && $past(power_down) |-> !line_tx_en && !fabric_rx_dv)
    else $error("traffic during power down");
an_time_a: assert property ($rose(autoneg_done) |-> pres_cnt >= AN_CYCLES)
    else $error("negotiation completed too early");
col_gen_a: assert property (fabric_col |-> s_tx_prev)
    else $error("collision without transmission");
rsv_zero_a: assert property (s_rd_ctl |=> mgmt_rdata[10] == 1'b0 && mgmt_rdata[6:0] == 7'h00)
    else $error("reserved control bits read nonzero");
endmodule // pbc_basic_control_chk

bind pbc_basic_control pbc_basic_control_chk #(.AN_CYCLES(AN_CYCLES)) u_chk (.mclk, .rst_b,
    .mgmt_index, .mgmt_read, .mgmt_rdata, .partner_present, .fabric_tx_en, .fabric_txd,
    .fabric_rx_dv, .fabric_rxd, .fabric_col, .line_rx_dv, .line_tx_en, .line_txd, .speed_100,
    .full_duplex, .power_down, .autoneg_done, .phy_regs_reset);

// ---- test/pbc_host.sv ----
/* Host management access model: one-cycle read and write strobes on mclk.
   Assumes the bench calls wr and rd one at a time. */
`timescale 1ns/1ps
module pbc_host (
    input  wire logic        mclk,
    input  wire logic [15:0] mgmt_rdata,
    output logic      [4:0]  mgmt_index,
    output logic             mgmt_write,
    output logic             mgmt_read,
    output logic      [15:0] mgmt_wdata
);
// ----------------------------------------
// Access tasks
// ----------------------------------------
initial begin
    mgmt_index = 5'h1f;
    mgmt_write = 1'b0;
    mgmt_read  = 1'b0;
    mgmt_wdata = 16'h0000;
end
task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    @(negedge mclk);
    mgmt_index <= idx;
    mgmt_wdata <= d;
    mgmt_write <= 1'b1;
    @(negedge mclk);
    mgmt_write <= 1'b0;
    mgmt_wdata <= ~d;
    mgmt_index <= ~idx;
endtask
task automatic rd(input logic [4:0] idx, output logic [15:0] d);
    @(negedge mclk);
    mgmt_index <= idx;
    mgmt_read  <= 1'b1;
    @(negedge mclk);
    mgmt_read  <= 1'b0;
    mgmt_index <= ~idx;
    @(negedge mclk);
    d = mgmt_rdata;
endtask
endmodule // pbc_host
